// ---- hw/jpeg_encoder_ctrl_status.sv ----
// Control, status, page-select and byte-wise access registers of the compression stage
`timescale 1ns/1ps
`include "jpeg_ctrl_regs.svh"

// Operation
// - A 3-bit page field at 0xF0, reset to 1, routes accesses to core, pipe page 1 or 2.
// - Address 0xF1 completes a 16-bit read or write as two successive byte transfers.
// - Setting control bit 0 starts compression at the next frame start, never mid-frame.
// - Control bit 1 hands the output FIFO and the sixteen re-order RAMs to register access.
// - In memory test one write reaches all 17 RAMs together and each RAM reads back alone.
// - Control bits 14 to 2 always read as zero.
// - Status bit 0 sets when a compressed image transfer completes and holds until cleared.
// - Clearing status bit 0 also clears the overflow, spoof and re-order error flags.
// - The clear only acts while the output buffer clock is running.
// - A FIFO overflow during a compressed transfer sets status bit 1 and ends it early.
// - A spoof frame too small for the stream sets status bit 2 until the done clear.
module jpeg_encoder_ctrl_status #(
    parameter int RAM_AW = 10,
    parameter int NRAM = `TEST_RAMS
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic reg_byte,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_rack,
    output logic [2:0] page_sel,
    input wire logic frame_start,
    input wire logic xfer_done_evt,
    input wire logic fifo_ovf_evt,
    input wire logic spoof_ovs_evt,
    input wire logic reorder_err_evt,
    input wire logic obuf_clk_alive,
    output logic encode_active,
    output logic xfer_abort,
    output logic mem_test_mode,
    output logic encoder_soft_reset,
    output jpeg_ctrl_pkg::seq_state_t seq_state,
    input wire logic test_wr,
    input wire logic test_bcast,
    input wire logic [4:0] test_ram_idx,
    input wire logic [RAM_AW-1:0] test_addr,
    input wire logic [15:0] test_wdata,
    input wire logic [NRAM*16-1:0] ram_rdata_all,
    output logic [NRAM-1:0] ram_test_we,
    output logic [RAM_AW-1:0] ram_test_addr,
    output logic [15:0] ram_test_wdata,
    output logic [15:0] test_rdata
);
    import jpeg_ctrl_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [2:0] page_r, page_nxt;
    logic [15:0] ctrl_r, ctrl_nxt;
    logic [3:0] stat_r, stat_nxt;
    logic [7:0] hi_r, hi_nxt;
    logic [7:0] lo_r, lo_nxt;
    logic [7:0] tgt_r, tgt_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    logic rack_r, rack_nxt;
    logic alive_s1_r, alive_s2_r;
    seq_state_t seq_r, seq_nxt;
    logic active_r, active_nxt;
    logic abort_r, abort_nxt;
    logic [NRAM-1:0] we_r, we_nxt;
    logic [RAM_AW-1:0] taddr_r, taddr_nxt;
    logic [15:0] twdata_r, twdata_nxt;
    logic [15:0] trdata_r, trdata_nxt;
    logic wr_go;
    logic [7:0] wr_a;
    logic [15:0] wr_d;
    logic srst;
    logic clr_req;
    logic [15:0] rd_val;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    // Page-2 registers answer only while the page field selects page 2
    function automatic logic hit_pipe2(input logic [7:0] a, input logic [2:0] pg,
                                       input logic [7:0] ofs);
        hit_pipe2 = (pg == `PAGE_PIPE2) && (a == ofs);
    endfunction

    function automatic logic [15:0] reg_value(input logic [7:0] a, input logic [2:0] pg,
                                              input logic [15:0] c, input logic [3:0] s);
        reg_value = 16'h0000;
        if (a == `PAGE_OFS) begin
            reg_value = {13'h0000, pg};
        end else if (hit_pipe2(a, pg, `CTRL_OFS)) begin
            reg_value = {c[`CTRL_SRST_BIT], 13'h0000, c[`CTRL_TEST_BIT:`CTRL_EN_BIT]};
        end else if (hit_pipe2(a, pg, `STAT_OFS)) begin
            reg_value = {12'h000, s};
        end
    endfunction

    // ------------------------------------------------------------
    // Register port and byte-wise access
    // ------------------------------------------------------------
    assign rd_val = reg_value(reg_addr, page_r, ctrl_r, stat_r);

    always_comb begin
        page_nxt = page_r;
        ctrl_nxt = ctrl_r;
        hi_nxt = hi_r;
        lo_nxt = lo_r;
        tgt_nxt = tgt_r;
        rdata_nxt = rdata_r;
        rack_nxt = 1'b0;
        wr_go = 1'b0;
        wr_a = reg_addr;
        wr_d = reg_wdata;
        if (reg_wr) begin
            if (reg_addr == `BYTE_OFS) begin
                // Low byte completes the word staged by the previous byte write
                wr_go = 1'b1;
                wr_a = tgt_r;
                wr_d = {hi_r, reg_wdata[7:0]};
            end else if (reg_byte) begin
                hi_nxt = reg_wdata[7:0];
                tgt_nxt = reg_addr;
            end else begin
                wr_go = 1'b1;
            end
        end
        if (wr_go) begin
            if (wr_a == `PAGE_OFS) begin
                page_nxt = wr_d[2:0];
            end else if (hit_pipe2(wr_a, page_r, `CTRL_OFS)) begin
                ctrl_nxt = 16'h0000;
                ctrl_nxt[`CTRL_EN_BIT] = wr_d[`CTRL_EN_BIT];
                ctrl_nxt[`CTRL_TEST_BIT] = wr_d[`CTRL_TEST_BIT];
                ctrl_nxt[`CTRL_SRST_BIT] = wr_d[`CTRL_SRST_BIT];
            end
        end
        if (reg_rd) begin
            rack_nxt = 1'b1;
            if (reg_addr == `BYTE_OFS) begin
                rdata_nxt = {8'h00, lo_r};
            end else if (reg_byte) begin
                rdata_nxt = {8'h00, rd_val[15:8]};
                lo_nxt = rd_val[7:0];
            end else begin
                rdata_nxt = rd_val;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            page_r <= `PAGE_RST;
            ctrl_r <= `CTRL_RST;
            hi_r <= 8'h00;
            lo_r <= 8'h00;
            tgt_r <= 8'h00;
            rdata_r <= `BYTE_RST;
            rack_r <= 1'b0;
        end else begin
            page_r <= page_nxt;
            ctrl_r <= ctrl_nxt;
            hi_r <= hi_nxt;
            lo_r <= lo_nxt;
            tgt_r <= tgt_nxt;
            rdata_r <= rdata_nxt;
            rack_r <= rack_nxt;
        end
    end

    // ------------------------------------------------------------
    // Output buffer clock presence synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            alive_s1_r <= 1'b0;
            alive_s2_r <= 1'b0;
        end else begin
            alive_s1_r <= obuf_clk_alive;
            alive_s2_r <= alive_s1_r;
        end
    end

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    assign srst = ctrl_r[`CTRL_SRST_BIT];
    // Acknowledge needs a running output buffer clock
    assign clr_req = wr_go && hit_pipe2(wr_a, page_r, `STAT_OFS)
                     && wr_d[`STAT_DONE_BIT] && alive_s2_r;

    always_comb begin
        stat_nxt = stat_r;
        if (clr_req) begin
            stat_nxt = `STAT_RST;
        end
        // New events win over a clear in the same cycle
        if (xfer_done_evt && active_r) begin
            stat_nxt[`STAT_DONE_BIT] = 1'b1;
        end
        if (fifo_ovf_evt && active_r) begin
            stat_nxt[`STAT_OVF_BIT] = 1'b1;
        end
        if (spoof_ovs_evt && active_r) begin
            stat_nxt[`STAT_SPOOF_BIT] = 1'b1;
        end
        if (reorder_err_evt) begin
            stat_nxt[`STAT_REORD_BIT] = 1'b1;
        end
        if (srst) begin
            stat_nxt = `STAT_RST;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stat_r <= `STAT_RST;
        end else begin
            stat_r <= stat_nxt;
        end
    end

    // ------------------------------------------------------------
    // Frame sequencer
    // ------------------------------------------------------------
    always_comb begin
        seq_nxt = seq_r;
        abort_nxt = 1'b0;
        case (seq_r)
            SEQ_IDLE: begin
                if (ctrl_r[`CTRL_EN_BIT]) begin
                    seq_nxt = SEQ_WAIT_FRAME;
                end
            end
            SEQ_WAIT_FRAME: begin
                if (!ctrl_r[`CTRL_EN_BIT]) begin
                    seq_nxt = SEQ_IDLE;
                end else if (frame_start) begin
                    seq_nxt = SEQ_ENCODE;
                end
            end
            SEQ_ENCODE: begin
                if (fifo_ovf_evt) begin
                    seq_nxt = SEQ_ABORT;
                    abort_nxt = 1'b1;
                end else if (xfer_done_evt) begin
                    seq_nxt = ctrl_r[`CTRL_EN_BIT] ? SEQ_WAIT_FRAME : SEQ_IDLE;
                end
            end
            SEQ_ABORT: begin
                seq_nxt = ctrl_r[`CTRL_EN_BIT] ? SEQ_WAIT_FRAME : SEQ_IDLE;
            end
            default: begin
                seq_nxt = SEQ_IDLE;
            end
        endcase
        if (srst || ctrl_r[`CTRL_TEST_BIT]) begin
            seq_nxt = SEQ_IDLE;
            abort_nxt = 1'b0;
        end
        active_nxt = (seq_nxt == SEQ_ENCODE);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            seq_r <= SEQ_IDLE;
            active_r <= 1'b0;
            abort_r <= 1'b0;
        end else begin
            seq_r <= seq_nxt;
            active_r <= active_nxt;
            abort_r <= abort_nxt;
        end
    end

    // ------------------------------------------------------------
    // Memory test access path
    // ------------------------------------------------------------
    generate
        for (genvar i = 0; i < NRAM; i++) begin : g_we
            // Broadcast reaches every RAM, otherwise only the indexed one
            always_comb begin
                we_nxt[i] = ctrl_r[`CTRL_TEST_BIT] && test_wr
                            && (test_bcast || (test_ram_idx == 5'(i)));
            end
        end
    endgenerate

    always_comb begin
        taddr_nxt = test_addr;
        twdata_nxt = test_wdata;
        trdata_nxt = 16'h0000;
        if (ctrl_r[`CTRL_TEST_BIT] && (32'(test_ram_idx) < NRAM)) begin
            trdata_nxt = ram_rdata_all[test_ram_idx*16 +: 16];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            we_r <= '0;
            taddr_r <= '0;
            twdata_r <= 16'h0000;
            trdata_r <= 16'h0000;
        end else begin
            we_r <= we_nxt;
            taddr_r <= taddr_nxt;
            twdata_r <= twdata_nxt;
            trdata_r <= trdata_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rdata = rdata_r;
    assign reg_rack = rack_r;
    assign page_sel = page_r;
    assign encode_active = active_r;
    assign xfer_abort = abort_r;
    assign mem_test_mode = ctrl_r[`CTRL_TEST_BIT];
    assign encoder_soft_reset = ctrl_r[`CTRL_SRST_BIT];
    assign seq_state = seq_r;
    assign ram_test_we = we_r;
    assign ram_test_addr = taddr_r;
    assign ram_test_wdata = twdata_r;
    assign test_rdata = trdata_r;

endmodule

// ---- hw/jpeg_ctrl_regs.svh ----
// Register offsets, field positions, reset values and page codes
`ifndef JPEG_CTRL_REGS_SVH
`define JPEG_CTRL_REGS_SVH
`define CTRL_OFS 8'h00
`define STAT_OFS 8'h02
`define PAGE_OFS 8'hF0
`define BYTE_OFS 8'hF1
`define PAGE_RST 3'h1
`define PAGE_CORE 3'h0
`define PAGE_PIPE1 3'h1
`define PAGE_PIPE2 3'h2
`define CTRL_RST 16'h0000
`define STAT_RST 4'h0
`define BYTE_RST 16'h0000
`define CTRL_EN_BIT 0
`define CTRL_TEST_BIT 1
`define CTRL_SRST_BIT 15
`define STAT_DONE_BIT 0
`define STAT_OVF_BIT 1
`define STAT_SPOOF_BIT 2
`define STAT_REORD_BIT 3
`define TEST_RAMS 17
`endif

// ---- hw/jpeg_ctrl_pkg.sv ----
// Types shared by the compression control block
package jpeg_ctrl_pkg;
    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_WAIT_FRAME,
        SEQ_ENCODE,
        SEQ_ABORT
    } seq_state_t;
endpackage

// ---- test/test_ram_model.sv ----
// Behavioural model of the output FIFO and re-order test RAMs
`timescale 1ns/1ps
module test_ram_model #(
    parameter int NRAM = 17,
    parameter int AW = 4
) (
    input wire logic clk_sys,
    input wire logic [NRAM-1:0] we,
    input wire logic [AW-1:0] addr,
    input wire logic [15:0] wdata,
    output logic [NRAM*16-1:0] rdata_all
);
    logic [15:0] mem [NRAM][2**AW];
    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < NRAM; i++) begin
            if (we[i]) begin
                mem[i][addr] <= wdata;
            end
        end
    end
    always_comb begin
        for (int i = 0; i < NRAM; i++) begin
            rdata_all[i*16+:16] = mem[i][addr];
        end
    end
endmodule

// ---- test/ctrl_status_props.sv ----
// Concurrent checks on the compression control register block
`timescale 1ns/1ps
module ctrl_status_props
    import jpeg_ctrl_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic reg_byte,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rack,
    input wire logic [2:0] page_sel,
    input wire logic frame_start,
    input wire logic xfer_done_evt,
    input wire logic fifo_ovf_evt,
    input wire logic encode_active,
    input wire logic xfer_abort,
    input wire logic mem_test_mode,
    input wire logic encoder_soft_reset,
    input wire logic [1:0] seq_state
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    wire p2 = page_sel == 3'h2;
    wire ctl_wr = reg_wr && !reg_byte && reg_addr == 8'h00 && p2;
    wire st_rd = reg_rd && !reg_byte && reg_addr == 8'h02 && p2;
    sequence done_seen;
        encode_active && xfer_done_evt && !encoder_soft_reset && !reg_wr;
    endsequence
    sequence flag_read;
        done_seen ##1 !reg_wr ##1 st_rd;
    endsequence
    rack_follows_a: assert property (reg_rd |=> reg_rack)
        else $error("read not answered");
    page_write_a: assert property (reg_wr && !reg_byte && reg_addr == 8'hf0
        |=> page_sel == $past(reg_wdata[2:0])) else $error("page field wrong");
    ctrl_unused_a: assert property (reg_rd && !reg_byte && reg_addr == 8'h00
        |=> reg_rdata[14:2] == 13'h0) else $error("unused control bits set");
    ctrl_mirror_a: assert property (ctl_wr |=> mem_test_mode == $past(reg_wdata[1])
        && encoder_soft_reset == $past(reg_wdata[15])) else $error("control bits wrong");
    encode_frame_a: assert property ($rose(encode_active) |-> $past(frame_start))
        else $error("encoding began mid frame");
    soft_idle_a: assert property (encoder_soft_reset [*2] |->
        seq_state == SEQ_IDLE && !encode_active) else $error("sequencer not held");
    overflow_abort_a: assert property (encode_active && fifo_ovf_evt && !reg_wr
        |=> xfer_abort && !encode_active) else $error("overflow did not abort");
    done_flag_a: assert property (flag_read |=> reg_rack && reg_rdata[0])
        else $error("done flag not read back");
endmodule
bind jpeg_encoder_ctrl_status ctrl_status_props u_props (.clk_sys(clk_sys), .rst_n(rst_n),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_byte(reg_byte), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rack(reg_rack), .page_sel(page_sel),
    .frame_start(frame_start), .xfer_done_evt(xfer_done_evt), .fifo_ovf_evt(fifo_ovf_evt),
    .encode_active(encode_active), .xfer_abort(xfer_abort), .mem_test_mode(mem_test_mode),
    .encoder_soft_reset(encoder_soft_reset), .seq_state(seq_state));

// ---- test/tb_top.sv ----
// Self-checking bench for the compression control register block
`timescale 1ns/1ps
module tb_top;
    import jpeg_ctrl_pkg::*;
    logic clk_sys = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, reg_byte = 0;
    logic [7:0] reg_addr = 0;
    logic [15:0] reg_wdata = 0, test_wdata = 0, reg_rdata, test_rdata, ram_test_wdata;
    logic reg_rack, encode_active, xfer_abort, mem_test_mode, encoder_soft_reset;
    logic obuf_clk_alive = 0, test_wr = 0, test_bcast = 0;
    logic [2:0] page_sel;
    logic [4:0] ev = 0, test_ram_idx = 0;
    logic [3:0] test_addr = 0, ram_test_addr;
    logic [16:0] ram_test_we;
    logic [271:0] ram_rdata_all;
    seq_state_t seq_state;
    int fail_count = 0, n_tests = 0;
    always #25 clk_sys = ~clk_sys;
    jpeg_encoder_ctrl_status #(.RAM_AW(4)) DUT (.clk_sys(clk_sys), .rst_n(rst_n),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_byte(reg_byte), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rack(reg_rack), .page_sel(page_sel),
        .frame_start(ev[0]), .xfer_done_evt(ev[1]), .fifo_ovf_evt(ev[2]),
        .spoof_ovs_evt(ev[3]), .reorder_err_evt(ev[4]), .obuf_clk_alive(obuf_clk_alive),
        .encode_active(encode_active), .xfer_abort(xfer_abort), .mem_test_mode(mem_test_mode),
        .encoder_soft_reset(encoder_soft_reset), .seq_state(seq_state), .test_wr(test_wr),
        .test_bcast(test_bcast), .test_ram_idx(test_ram_idx), .test_addr(test_addr),
        .test_wdata(test_wdata), .ram_rdata_all(ram_rdata_all), .ram_test_we(ram_test_we),
        .ram_test_addr(ram_test_addr), .ram_test_wdata(ram_test_wdata),
        .test_rdata(test_rdata));
    test_ram_model #(.AW(4)) RAM (.clk_sys(clk_sys), .we(ram_test_we), .addr(ram_test_addr),
        .wdata(ram_test_wdata), .rdata_all(ram_rdata_all));
    // ------------------------------
    // Access tasks
    // ------------------------------
    task automatic chk(input string nm, input logic [16:0] e, input logic [16:0] g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic b = 0);
        @(negedge clk_sys);
        {reg_wr, reg_addr, reg_wdata, reg_byte} = {1'b1, a, d, b};
        @(negedge clk_sys);
        reg_wr = 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [16:0] e, input logic b = 0);
        @(negedge clk_sys);
        {reg_rd, reg_addr, reg_byte} = {1'b1, a, b};
        @(negedge clk_sys);
        reg_rd = 0;
        chk("rack", 1, reg_rack);
        chk("rdata", e, reg_rdata);
    endtask
    task automatic pulse(input int i);
        @(negedge clk_sys);
        ev[i] = 1;
        @(negedge clk_sys);
        ev[i] = 0;
    endtask
    task automatic tw(input logic bc, input logic [4:0] ix, input logic [15:0] d);
        @(negedge clk_sys);
        {test_wr, test_bcast, test_ram_idx, test_addr, test_wdata} = {1'b1, bc, ix, 4'h3, d};
        @(negedge clk_sys);
        test_wr = 0;
        chk("we", bc ? 17'h1_ffff : 17'h1 << ix, ram_test_we);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ------------------------------
    // Tests
    // ------------------------------
    initial begin
        #400_000;
        fail_count++;
        complete_run();
    end
    initial begin
        repeat (10) @(negedge clk_sys);
        rst_n = 1;
        chk("page", 1, page_sel);
        for (int p = 0; p < 3; p++) begin
            wr(8'hf0, 16'(p));
            rd(8'hf0, 17'(p));
        end
        wr(8'h00, 16'h7ffe);
        rd(8'h00, 17'h2);
        chk("test", 1, mem_test_mode);
        tw(1, 0, 16'h1234);
        tw(0, 5, 16'hbeef);
        for (int i = 0; i < 17; i++) begin
            @(negedge clk_sys);
            test_ram_idx = 5'(i);
            repeat (2) @(negedge clk_sys);
            chk("ram", i == 5 ? 17'h0_beef : 17'h0_1234, test_rdata);
        end
        wr(8'h00, 16'h0001);
        chk("armed", 0, encode_active);
        pulse(1);
        rd(8'h02, 0);
        pulse(0);
        chk("active", 1, encode_active);
        pulse(3);
        pulse(4);
        pulse(1);
        rd(8'h02, 17'hd);
        wr(8'h02, 0);
        rd(8'h02, 17'hd);
        wr(8'h02, 1);
        rd(8'h02, 17'hd);
        obuf_clk_alive = 1;
        repeat (4) @(negedge clk_sys);
        wr(8'h02, 1);
        rd(8'h02, 0);
        pulse(0);
        pulse(2);
        chk("abort", 1, xfer_abort);
        chk("active", 0, encode_active);
        rd(8'h02, 17'h2);
        wr(8'h00, 16'h8000);
        pulse(4);
        rd(8'h02, 0);
        chk("seq", SEQ_IDLE, seq_state);
        wr(8'h00, 16'h0080, 1);
        wr(8'hf1, 16'h0003);
        rd(8'h00, 17'h8003);
        chk("srst", 1, encoder_soft_reset);
        rd(8'h00, 17'h80, 1);
        rd(8'hf1, 17'h3, 1);
        rd(8'h10, 0);
        complete_run();
    end
endmodule
